// file: core/scr_pkg.sv
// Shared constants, types and register map of the section clear release block
package scr_pkg;

	// Clock rate and derived cycle counts
	localparam int unsigned CLK_HZ          = 250_000_000;   // System clock rate
	localparam int unsigned KEY_HOLD_S      = 2;             // Least reset key hold, seconds
	localparam int unsigned KEY_HOLD_CYC    = KEY_HOLD_S * CLK_HZ;
	localparam int unsigned RELAY_LIMIT_MS  = 50;            // Relay restore time limit, ms
	localparam int unsigned RELAY_LIMIT_CYC = RELAY_LIMIT_MS * (CLK_HZ / 1000);

	// Counter width default
	localparam int unsigned CNT_W_DEF = 8;                   // Axle count register width

	// Register byte offsets (one 32-bit word each)
	localparam logic [7:0] REG_CTRL   = 8'h00;               // Control, read/write
	localparam logic [7:0] REG_STATUS = 8'h04;               // Section status, read only
	localparam logic [7:0] REG_COUNT  = 8'h08;               // Axle count, read only
	localparam logic [7:0] REG_FAULT  = 8'h0c;               // Sticky relay faults, read only

	// Control fields and reset value
	localparam int unsigned CTRL_PAIR_LSB = 0;               // Two reset pair enables
	localparam int unsigned CTRL_INH_BIT  = 2;               // Force restrictive
	localparam logic [2:0]  CTRL_RST      = 3'h3;            // Both pairs in use, no inhibit

	// Status field positions
	localparam int unsigned ST_CLEAR_BIT  = 0;
	localparam int unsigned ST_BLOCK_BIT  = 1;
	localparam int unsigned ST_FAULT_BIT  = 2;
	localparam int unsigned ST_LIVE_BIT   = 3;
	localparam int unsigned ST_SEQ_LSB    = 4;
	localparam int unsigned ST_DEFECT_LSB = 7;
	localparam int unsigned ST_COIL_BIT   = 9;

	// Counter state after reset: blocked until a key reset
	localparam logic BLOCK_RST = 1'b1;

	// Relay count in the module
	localparam int unsigned NUM_RELAYS = 7;

	// One bit per safety relay
	typedef struct packed {
		logic vote;     // Occupancy vote relay
		logic occ_b;    // Occupied relay b
		logic occ_a;    // Occupied relay a
		logic hold;     // Hold drop relay
		logic line;     // Line release relay
		logic sens_b;   // Sensor release relay b
		logic sens_a;   // Sensor release relay a
	} scr_relay_s;

	// Front panel indicators
	typedef struct packed {
		logic line_green;   // Line release relay up
		logic vote_green;   // Occupancy vote relay up
		logic hold_red;     // Hold drop relay up
		logic occ_a_red;    // Occupied relay a up
		logic occ_b_red;    // Occupied relay b up
		logic cnt_occ_a;    // Counter occupied lamp a
		logic cnt_occ_b;    // Counter occupied lamp b
		logic cnt_free_a;   // Counter free lamp a
		logic cnt_free_b;   // Counter free lamp b
	} scr_led_s;

	// Reset sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_CLEAR,
		SEQ_SIM_IN,
		SEQ_SIM_OUT,
		SEQ_RESTORE,
		SEQ_DONE,
		SEQ_REFUSE
	} scr_seq_e;

endpackage

// file: core/scr_relay_chk.sv
// Contact supervision for one safety relay: antivalence and restore time limit
`timescale 1ns/1ps
module scr_relay_chk #(
	parameter int unsigned LIMIT_CYC = scr_pkg::RELAY_LIMIT_CYC
) (
	input  wire logic clk_i,     // System clock
	input  wire logic rst_i,     // Synchronous reset, active high
	input  wire logic coil_i,    // Commanded coil state
	input  wire logic no_i,      // Front contact read-back
	input  wire logic nc_i,      // Back contact read-back
	input  wire logic clr_i,     // Clear sticky fault
	output logic      up_o,      // Proven energized
	output logic      down_o,    // Proven released
	output logic      live_o,    // Wrong state beyond the limit, now
	output logic      fault_o    // Sticky fault
);
	import scr_pkg::*;

	logic [31:0] wait_ff;        // Cycles spent out of the commanded state
	logic        fault_ff;       // Sticky fault flag
	logic        mismatch;       // Contacts disagree with the coil

	// Only one contact of the pair set proves a state; equal members prove nothing
	function automatic logic only_first(input logic a, input logic b);
		return a & ~b;
	endfunction

	assign up_o     = only_first(no_i, nc_i);  // (R11) (R13)
	assign down_o   = only_first(nc_i, no_i);  // (R11) (R13)
	assign mismatch = coil_i ? ~up_o : ~down_o;
	assign live_o   = (wait_ff == LIMIT_CYC);
	assign fault_o  = fault_ff;

	// Time the transit on every actuation; saturate at the limit
	always_ff @(posedge clk_i) begin
		if (rst_i || !mismatch) begin
			wait_ff <= 32'h0;
		end else if (!live_o) begin
			wait_ff <= wait_ff + 32'h1;  // (R12)
		end
	end

	// Sticky fault; a live fault wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_ff <= 1'b0;
		end else if (live_o) begin
			fault_ff <= 1'b1;  // (R12)
		end else if (clr_i) begin
			fault_ff <= 1'b0;
		end
	end

endmodule

// file: core/scr_section.sv
// Section clear release: relay voting, axle counter, reset sequencer, Wishbone registers
// Notes on behaviour
// (R1) Amplifier loop closed while clear, opens on entry
// (R2) Line relay needs both sensor relays up
// (R3) Both sensor relays down energize hold drop
// (R4) Amplifier pulses count axles in and out
// (R5) Nonzero count drops free, raises occupied outputs
// (R6) Vote relay held by both occupied back contacts
// (R7) Clear needs line up, hold down, vote up
// (R8) Counter lamps show occupied or free state
// (R9) Clear: line, vote green; others dark
// (R10) Occupied: hold, occupied relays red; others dark
// (R11) Equal contact pair members mean relay fault
// (R12) Relay must restore within time limit
// (R13) Independent contact movement never permits clear
// (R14) Reset key starts the reset sequencer
// (R15) Reset refused while any fault persists
// (R16) Clear counter, simulate in and out, restore
// (R17) Four reset channels driven as two pairs
// (R18) Lit channel lamps; odd pair means defect
// (R19) Key held at least two seconds
// (R20) Minus count blocks until reset sequence
// (R21) Unused reset pair affects nothing else
`timescale 1ns/1ps
module scr_section #(
	parameter int unsigned CNT_W     = scr_pkg::CNT_W_DEF,        // Axle count width
	parameter int unsigned KEY_CYC   = scr_pkg::KEY_HOLD_CYC,     // Key hold in cycles
	parameter int unsigned RELAY_CYC = scr_pkg::RELAY_LIMIT_CYC   // Relay limit in cycles
) (
	input  wire logic               clk_i,                // 250 MHz system clock
	input  wire logic               rst_i,                // Synchronous reset, active high
	input  wire logic               wb_cyc_i,             // Wishbone cycle
	input  wire logic               wb_stb_i,             // Wishbone strobe
	input  wire logic               wb_we_i,              // Wishbone write enable
	input  wire logic [7:0]         wb_adr_i,             // Wishbone byte address
	input  wire logic [3:0]         wb_sel_i,             // Wishbone byte selects
	input  wire logic [31:0]        wb_dat_i,             // Wishbone write data
	output logic      [31:0]        wb_dat_o,             // Wishbone read data
	output logic                    wb_ack_o,             // Wishbone acknowledge
	input  wire logic               entry_release_loop_i, // Amplifier loop, high when closed
	input  wire logic               count_pulse_in_i,     // Axle entering pulse
	input  wire logic               count_pulse_out_i,    // Axle leaving pulse
	input  wire logic               reset_key_i,          // Reset key contact
	input  wire scr_pkg::scr_relay_s relay_no_i,          // Front contact read-back
	input  wire scr_pkg::scr_relay_s relay_nc_i,          // Back contact read-back
	output scr_pkg::scr_relay_s     relay_coil_o,         // Relay coil drive
	output logic                    clear_line_o,         // Clear to signal circuit
	output scr_pkg::scr_led_s       led_o,                // Panel indicators
	output logic      [3:0]         reset_chan_o,         // Reset channels 1.1 1.2 2.1 2.2
	output logic      [3:0]         reset_led_o,          // Reset channel lamps
	input  wire logic [3:0]         reset_chan_fb_i,      // Reset channel lamp read-back
	output logic      [1:0]         pair_defect_o         // Defective reset pair
);
	import scr_pkg::*;

	// Relay supervision results
	scr_relay_s        coil_ff;         // Registered coil commands
	scr_relay_s        up;              // Proven energized
	scr_relay_s        down;            // Proven released
	scr_relay_s        live;            // Present faults
	scr_relay_s        fault;           // Sticky faults
	logic              fault_any;       // Any sticky fault
	logic              fault_live;      // Any present fault

	// Axle counter
	logic [CNT_W-1:0]  cnt_ff;          // Axles in the section
	logic              block_ff;        // Minus count or overflow block
	logic              in_prev_ff;      // Pulse edge buffer, entering
	logic              out_prev_ff;     // Pulse edge buffer, leaving
	logic              rearm_ff;        // Count returned to zero by a leaving axle
	logic              in_edge;         // Entering axle event
	logic              out_edge;        // Leaving axle event
	logic              free_out;        // Counter free outputs a and b
	logic              occ_out;         // Counter occupied outputs a and b

	// Reset sequencer
	scr_seq_e          seq_ff;          // Sequencer state
	logic [31:0]       hold_ff;         // Key held cycles
	logic              key_done;        // Key held long enough
	logic              seq_busy;        // Sequencer owns the counter
	logic              chan_on;         // Reset channels active
	logic [3:0]        chan_ff;         // Registered channel drive
	logic [1:0]        defect_ff;       // Sticky pair defect

	// Registers and outputs
	logic [2:0]        ctrl_ff;         // Pair enables and inhibit
	logic              ack_ff;          // Wishbone acknowledge
	logic [31:0]       rdat_ff;         // Wishbone read data
	logic              clear_ff;        // Registered clear line
	scr_led_s          led_ff;          // Registered indicators
	scr_relay_s        nxt_coil;        // Next coil commands
	logic [31:0]       rd_mux;          // Read data selection
	logic              wb_req;          // Request not yet answered

	// One supervisor per relay
	for (genvar i = 0; i < NUM_RELAYS; i++) begin : g_chk
		scr_relay_chk #(
			.LIMIT_CYC (RELAY_CYC)
		) u_chk (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.coil_i  (coil_ff[i]),
			.no_i    (relay_no_i[i]),
			.nc_i    (relay_nc_i[i]),
			.clr_i   (seq_ff == SEQ_CLEAR),
			.up_o    (up[i]),
			.down_o  (down[i]),
			.live_o  (live[i]),
			.fault_o (fault[i])
		);
	end

	assign fault_any  = |fault;   // (R11)
	assign fault_live = |live;    // (R15)

	// Counter outputs; a block reads as occupied whatever the count
	assign free_out = (cnt_ff == '0) && !block_ff;  // (R5) (R20)
	assign occ_out  = !free_out;                     // (R5)

	// Pulses are edge detected so a long pulse counts once
	assign in_edge  = count_pulse_in_i & ~in_prev_ff;
	assign out_edge = count_pulse_out_i & ~out_prev_ff;

	assign seq_busy = (seq_ff == SEQ_CLEAR) || (seq_ff == SEQ_SIM_IN) ||
	                  (seq_ff == SEQ_SIM_OUT);
	assign chan_on  = seq_busy || (seq_ff == SEQ_RESTORE);
	assign key_done = (hold_ff >= KEY_CYC - 1);

	// Pulse edge buffers, emptied by the sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_ff == SEQ_CLEAR) begin
			in_prev_ff  <= 1'b0;
			out_prev_ff <= 1'b0;
		end else begin
			in_prev_ff  <= count_pulse_in_i;
			out_prev_ff <= count_pulse_out_i;
		end
	end

	// Axle count; external pulses are ignored while the sequencer owns it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff   <= '0;
			block_ff <= BLOCK_RST;
			rearm_ff <= 1'b0;
		end else begin
			rearm_ff <= 1'b0;
			unique case (seq_ff)
				SEQ_CLEAR: begin
					cnt_ff   <= '0;       // (R16)
					block_ff <= 1'b0;     // (R20)
				end
				SEQ_SIM_IN: begin
					cnt_ff <= cnt_ff + 1'b1;  // (R16)
				end
				SEQ_SIM_OUT: begin
					cnt_ff <= cnt_ff - 1'b1;  // (R16)
				end
				default: begin
					if (in_edge && !out_edge) begin
						// Overflow is unsafe to wrap, so it blocks too
						if (&cnt_ff) begin
							block_ff <= 1'b1;
						end else begin
							cnt_ff <= cnt_ff + 1'b1;  // (R4)
						end
					end else if (out_edge && !in_edge) begin
						if (cnt_ff == '0) begin
							block_ff <= 1'b1;  // (R20)
						end else begin
							cnt_ff   <= cnt_ff - 1'b1;  // (R4)
							rearm_ff <= (cnt_ff == 1) && !block_ff;
						end
					end
				end
			endcase
		end
	end

	// Coil logic: sensor coils from the loop, occupied coils from the count, others from proven contact states
	always_comb begin
		nxt_coil        = '0;
		nxt_coil.sens_a = entry_release_loop_i;  // (R1)
		nxt_coil.sens_b = entry_release_loop_i;  // (R1)
		nxt_coil.hold   = down.sens_a & down.sens_b;  // (R3)
		nxt_coil.occ_a  = occ_out;  // (R5)
		nxt_coil.occ_b  = occ_out;  // (R5)
		nxt_coil.vote   = down.occ_a & down.occ_b;  // (R6)
		// Line relay sticks on its own drive; picks up on a restore or a clean exit
		nxt_coil.line   = up.sens_a & up.sens_b & free_out & !fault_any &
		                  (coil_ff.line | rearm_ff | (seq_ff == SEQ_RESTORE));  // (R2) (R16)
	end

	// Coil register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coil_ff <= '0;
		end else begin
			coil_ff <= nxt_coil;
		end
	end

	// Clear line and relay lamps from proven contacts; counter lamps from the count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clear_ff <= 1'b0;
			led_ff   <= '0;
		end else begin
			clear_ff <= up.line & down.hold & up.vote & !fault_any &
			            !ctrl_ff[CTRL_INH_BIT];  // (R7) (R11) (R13)
			led_ff.line_green <= up.line;   // (R9)
			led_ff.vote_green <= up.vote;   // (R9)
			led_ff.hold_red   <= up.hold;   // (R10)
			led_ff.occ_a_red  <= up.occ_a;  // (R10)
			led_ff.occ_b_red  <= up.occ_b;  // (R10)
			led_ff.cnt_occ_a  <= occ_out;   // (R8)
			led_ff.cnt_occ_b  <= occ_out;   // (R8)
			led_ff.cnt_free_a <= free_out;  // (R8)
			led_ff.cnt_free_b <= free_out;  // (R8)
		end
	end

	// Key hold timer, runs while the key stays closed
	always_ff @(posedge clk_i) begin
		if (rst_i || !reset_key_i) begin
			hold_ff <= 32'h0;
		end else if (!key_done) begin
			hold_ff <= hold_ff + 32'h1;  // (R19)
		end
	end

	// Reset sequencer; letting go early abandons the restore
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_ff <= SEQ_IDLE;
		end else begin
			unique case (seq_ff)
				SEQ_IDLE: begin
					if (reset_key_i) begin
						seq_ff <= fault_live ? SEQ_REFUSE : SEQ_CLEAR;  // (R14) (R15)
					end
				end
				SEQ_CLEAR: begin
					seq_ff <= reset_key_i ? SEQ_SIM_IN : SEQ_IDLE;  // (R16)
				end
				SEQ_SIM_IN: begin
					seq_ff <= reset_key_i ? SEQ_SIM_OUT : SEQ_IDLE;  // (R16)
				end
				SEQ_SIM_OUT: begin
					seq_ff <= reset_key_i ? SEQ_RESTORE : SEQ_IDLE;  // (R16)
				end
				SEQ_RESTORE: begin
					if (!reset_key_i) begin
						seq_ff <= SEQ_IDLE;
					end else if (key_done) begin
						seq_ff <= SEQ_DONE;  // (R19)
					end
				end
				SEQ_DONE, SEQ_REFUSE: begin
					// Wait for release so a held key cannot loop
					if (!reset_key_i) begin
						seq_ff <= SEQ_IDLE;
					end
				end
			endcase
		end
	end

	// Reset channels in pairs; a disabled pair stays dark
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_ff <= 4'h0;
		end else begin
			chan_ff[1:0] <= {2{chan_on & ctrl_ff[CTRL_PAIR_LSB]}};      // (R17) (R21)
			chan_ff[3:2] <= {2{chan_on & ctrl_ff[CTRL_PAIR_LSB + 1]}};  // (R17) (R21)
		end
	end

	// Lamp read-back check per pair; a new key press clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			defect_ff <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (chan_ff[2*p] && reset_chan_fb_i[2*p +: 2] != 2'h3) begin
					defect_ff[p] <= 1'b1;  // (R18)
				end else if (seq_ff == SEQ_IDLE && reset_key_i) begin
					defect_ff[p] <= 1'b0;
				end
			end
		end
	end

	// Wishbone: one wait state, ack drops the cycle after it rose
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;

	always_comb begin
		rd_mux = 32'h0;
		unique case (wb_adr_i)
			REG_CTRL: begin
				rd_mux[2:0] = ctrl_ff;
			end
			REG_STATUS: begin
				rd_mux[ST_CLEAR_BIT]               = clear_ff;
				rd_mux[ST_BLOCK_BIT]               = block_ff;
				rd_mux[ST_FAULT_BIT]               = fault_any;
				rd_mux[ST_LIVE_BIT]                = fault_live;
				rd_mux[ST_SEQ_LSB +: 3]            = seq_ff;
				rd_mux[ST_DEFECT_LSB +: 2]         = defect_ff;
				rd_mux[ST_COIL_BIT]                = coil_ff.line;
			end
			REG_COUNT: begin
				rd_mux[CNT_W-1:0] = cnt_ff;
			end
			REG_FAULT: begin
				rd_mux[NUM_RELAYS-1:0] = fault;
			end
			default: begin
				// Unmapped addresses read zero and ignore writes
				rd_mux = 32'h0;
			end
		endcase
	end

	// Bus answer and control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0;
			ctrl_ff <= CTRL_RST;
		end else begin
			ack_ff <= wb_req;
			if (wb_req) begin
				rdat_ff <= wb_we_i ? 32'h0 : rd_mux;
				if (wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
					ctrl_ff <= wb_dat_i[2:0];
				end
			end
		end
	end

	assign wb_ack_o      = ack_ff;
	assign wb_dat_o      = rdat_ff;
	assign relay_coil_o  = coil_ff;
	assign clear_line_o  = clear_ff;
	assign led_o         = led_ff;
	assign reset_chan_o  = chan_ff;
	assign reset_led_o   = chan_ff;  // (R18)
	assign pair_defect_o = defect_ff;

endmodule

// file: verification/scr_section_properties.sv
// Port-level assertions for the section clear release block
`timescale 1ns/1ps
module scr_section_chk
	import scr_pkg::*;
(
	input wire logic       clk_i,            // System clock
	input wire logic       rst_i,            // Synchronous reset
	input wire logic       wb_cyc_i,         // Bus cycle
	input wire logic       wb_stb_i,         // Bus strobe
	input wire logic       wb_ack_o,         // Bus acknowledge
	input wire logic       reset_key_i,      // Reset key
	input wire scr_relay_s relay_no_i,       // Front contacts
	input wire scr_relay_s relay_nc_i,       // Back contacts
	input wire scr_relay_s relay_coil_o,     // Coil drive
	input wire logic       clear_line_o,     // Clear output
	input wire scr_led_s   led_o,            // Panel lamps
	input wire logic [3:0] reset_chan_o,     // Reset channels
	input wire logic [3:0] reset_led_o,      // Channel lamps
	input wire logic [3:0] reset_chan_fb_i,  // Lamp read-back
	input wire logic [1:0] pair_defect_o     // Pair defects
);
	scr_relay_s up;  // Proven energized
	scr_relay_s dn;  // Proven released

	// Contact pairs must disagree to prove a state
	assign up = scr_relay_s'(relay_no_i & ~relay_nc_i);
	assign dn = scr_relay_s'(relay_nc_i & ~relay_no_i);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Two edges past reset, so registered outputs reflect inputs
	sequence s_settled;
		!$past(rst_i) && !$past(rst_i, 2);
	endsequence
	// Key released for three edges
	sequence s_key_off;
		!reset_key_i ##1 !reset_key_i ##1 !reset_key_i;
	endsequence

	property p_clear_cause;
		clear_line_o |-> $past(up.line && dn.hold && up.vote);
	endproperty
	a_clear_cause: assert property (p_clear_cause)
		else $error("clear line without all three relays in place");
	property p_line_coil;
		relay_coil_o.line |-> $past(up.sens_a && up.sens_b);
	endproperty
	a_line_coil: assert property (p_line_coil)
		else $error("line relay driven without both sensor relays up");
	property p_hold_coil;
		s_settled |-> relay_coil_o.hold == $past(dn.sens_a && dn.sens_b);
	endproperty
	a_hold_coil: assert property (p_hold_coil)
		else $error("hold drop coil does not follow sensor relays");
	property p_vote_coil;
		s_settled |-> relay_coil_o.vote == $past(dn.occ_a && dn.occ_b);
	endproperty
	a_vote_coil: assert property (p_vote_coil)
		else $error("vote coil does not follow occupied relays");
	property p_panel;
		s_settled |-> led_o.line_green == $past(up.line) && led_o.hold_red == $past(up.hold)
			&& led_o.vote_green == $past(up.vote);
	endproperty
	a_panel: assert property (p_panel)
		else $error("panel lamps disagree with relay states");
	property p_pairs;
		reset_chan_o[0] == reset_chan_o[1] && reset_chan_o[2] == reset_chan_o[3]
			&& reset_led_o == reset_chan_o;
	endproperty
	a_pairs: assert property (p_pairs)
		else $error("reset channels not driven in pairs");
	property p_key_off;
		s_key_off |-> reset_chan_o == 4'h0;
	endproperty
	a_key_off: assert property (p_key_off)
		else $error("reset channels active without the key");
	property p_chan_start;
		$rose(reset_chan_o[0]) |-> $past(reset_key_i);
	endproperty
	a_chan_start: assert property (p_chan_start)
		else $error("reset channels started without the key");
	property p_defect_a;
		$rose(pair_defect_o[0]) |-> $past(reset_chan_o[0]) && $past(reset_chan_fb_i[1:0]) != 2'h3;
	endproperty
	a_defect_a: assert property (p_defect_a)
		else $error("pair one defect without a dark lamp");
	property p_defect_b;
		$rose(pair_defect_o[1]) |-> $past(reset_chan_o[2]) && $past(reset_chan_fb_i[3:2]) != 2'h3;
	endproperty
	a_defect_b: assert property (p_defect_b)
		else $error("pair two defect without a dark lamp");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer not a one cycle pulse after one cycle");
endmodule

bind scr_section scr_section_chk scr_section_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .reset_key_i, .relay_no_i, .relay_nc_i, .relay_coil_o, .clear_line_o, .led_o,
	.reset_chan_o, .reset_led_o, .reset_chan_fb_i, .pair_defect_o);

// file: verification/scr_relay_bank.sv
// Far-side model: force-guided safety relays and reset channel lamps
`timescale 1ns/1ps
module scr_relay_bank
	import scr_pkg::*;
(
	input  wire logic       clk_i,    // System clock
	input  wire scr_relay_s coil_i,   // Coil drive
	input  wire scr_relay_s stuck_i,  // Relays frozen by the bench
	input  wire logic [3:0] chan_i,   // Reset channels
	input  wire logic [3:0] dark_i,   // Broken lamps
	output scr_relay_s      no_o,     // Front contacts
	output scr_relay_s      nc_o,     // Back contacts
	output logic      [3:0] fb_o      // Lamp read-back
);
	scr_relay_s pos_ff = '0;  // Armature position

	// Armature follows coil in one cycle unless frozen
	always_ff @(posedge clk_i) begin
		pos_ff <= scr_relay_s'((coil_i & ~stuck_i) | (pos_ff & stuck_i));
	end

	// Guided contacts always move together as a pair
	assign no_o = pos_ff;
	assign nc_o = ~pos_ff;
	// Lamp lit only when its channel drives and bulb is whole
	assign fb_o = chan_i & ~dark_i;
endmodule

// file: verification/scr_section_bench.sv
// Self-checking bench for the section clear release block
`timescale 1ns/1ps
module scr_section_bench;
	import scr_pkg::*;
	localparam int unsigned KC = 40;  // Shortened key hold
	logic        clk_i = 1'b0;        // System clock
	logic        rst_i = 1'b1;        // Reset
	logic        cyc = 1'b0;          // Bus cycle and strobe
	logic        we = 1'b0;           // Bus direction
	logic [7:0]  adr = 8'h00;         // Bus address
	logic [31:0] wdat = 32'h0;        // Write data
	logic [31:0] rdat;                // Read data
	logic        ack;                 // Bus answer
	logic        loop = 1'b1;         // Entry loop closed
	logic        pin = 1'b0;          // Count in
	logic        pout = 1'b0;         // Count out
	logic        key = 1'b0;          // Reset key
	scr_relay_s  no;                  // Front contacts
	scr_relay_s  nc;                  // Back contacts
	scr_relay_s  coil;                // Coils
	scr_relay_s  stuck = '0;          // Frozen relays
	logic        clear;               // Clear line
	scr_led_s    led;                 // Panel
	logic [3:0]  chan;                // Channels
	logic [3:0]  fb;                  // Lamp read-back
	logic [3:0]  dark = 4'h0;         // Broken lamps
	logic [1:0]  defect;              // Pair defects
	logic [15:0] rnd = 16'h88f4;      // Fixed seed
	logic [63:0] exp_q[$];            // Mask and expected read
	logic [63:0] note;                // Oldest note
	int          n;                   // Axle count
	int          failures = 0;
	int          check_count = 0;

	initial forever #2 clk_i = ~clk_i;

	scr_section #(.CNT_W(8), .KEY_CYC(KC), .RELAY_CYC(8)) scr_section_inst (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.entry_release_loop_i(loop), .count_pulse_in_i(pin), .count_pulse_out_i(pout),
		.reset_key_i(key), .relay_no_i(no), .relay_nc_i(nc), .relay_coil_o(coil),
		.clear_line_o(clear), .led_o(led), .reset_chan_o(chan), .reset_led_o(),
		.reset_chan_fb_i(fb), .pair_defect_o(defect));
	scr_relay_bank scr_relay_bank_inst (.clk_i(clk_i), .coil_i(coil), .stuck_i(stuck),
		.chan_i(chan), .dark_i(dark), .no_o(no), .nc_o(nc), .fb_o(fb));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic give_verdict();
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask

	// Classic single cycle; held until the answer is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back({m, e & m});
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0, m, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 32'h0, 32'h0);
	endtask

	// Axle pulses, two cycles high and two low
	task automatic axles(input logic o, input int k);
		repeat (k) begin
			if (o)
				pout <= 1'b1;
			else
				pin <= 1'b1;
			repeat (2) @(posedge clk_i);
			pout <= 1'b0;
			pin <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask

	// Key held past the hold time so the whole sequence runs
	task automatic key_reset(input logic [3:0] ch);
		key <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("reset_chan_o", 32'(ch), 32'(chan));
		repeat (KC) @(posedge clk_i);
		key <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask

	// Read answers checked against the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1) begin
			note = exp_q.pop_front();
			if (note[63:32] != 32'h0) begin
				check_count++;
				if ((rdat & note[63:32]) !== note[31:0]) begin
					failures++;
					$display("wrong value wb_dat_o expected %h seen %h", note[31:0], rdat);
				end
			end
		end
	end

	// Hang guard
	initial begin
		repeat (6000) @(posedge clk_i);
		failures++;
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(REG_CTRL, 32'h7, 32'(CTRL_RST));
		rd(REG_STATUS, 32'h3, 32'h2);
		rnd = lfsr(rnd);
		wr(8'h10, {16'h0, rnd});
		rd(8'h10, 32'hffffffff, 32'h0);
		wr(REG_COUNT, {16'h0, rnd});
		rd(REG_COUNT, 32'hff, 32'h0);
		key_reset(4'hf);
		rd(REG_STATUS, 32'h3ff, 32'h201);
		chk("led_o", 32'h183, 32'(led));
		// Train passes through
		rnd = lfsr(rnd);
		n = 2 + int'(rnd[1:0]);
		loop <= 1'b0;
		axles(1'b0, n);
		chk("clear_line_o", 32'h0, 32'(clear));
		chk("led_o", 32'h07c, 32'(led));
		rd(REG_COUNT, 32'hff, 32'(n));
		loop <= 1'b1;
		axles(1'b1, n);
		chk("clear_line_o", 32'h1, 32'(clear));
		// Minus count stays blocked
		axles(1'b1, 1);
		rd(REG_STATUS, 32'h3, 32'h2);
		axles(1'b0, 2);
		rd(REG_STATUS, 32'h3, 32'h2);
		dark <= 4'h8;
		key_reset(4'hf);
		chk("pair_defect_o", 32'h2, 32'(defect));
		wr(REG_CTRL, 32'h7);
		chk("clear_line_o", 32'h0, 32'(clear));
		wr(REG_CTRL, 32'h3);
		// Occupied relay a fails to pick up
		stuck <= scr_relay_s'(7'h10);
		axles(1'b0, 1);
		repeat (12) @(posedge clk_i);
		rd(REG_FAULT, 32'h7f, 32'h10);
		rd(REG_STATUS, 32'hd, 32'hc);
		key <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("reset_chan_o", 32'h0, 32'(chan));
		rd(REG_STATUS, 32'h70, 32'h60);
		key <= 1'b0;
		stuck <= '0;
		axles(1'b1, 1);
		key_reset(4'hf);
		rd(REG_FAULT, 32'h7f, 32'h0);
		// One pair in use, one of its lamps dark
		wr(REG_CTRL, 32'h1);
		dark <= 4'h2;
		key_reset(4'h3);
		chk("pair_defect_o", 32'h1, 32'(defect));
		rd(REG_STATUS, 32'h3, 32'h1);
		give_verdict();
	end
endmodule
